// File: rtl/adc_sel_params.svh
`ifndef ADC_SEL_PARAMS_SVH
`define ADC_SEL_PARAMS_SVH

// ****************************************************************
// Register offsets and field positions.
// ****************************************************************
`define OFF_SEL_TEMP 8'h00
`define OFF_CTRL_A 8'h04
`define OFF_CTRL_B 8'h08
`define OFF_SEL_APPLIED 8'h0C
`define OFF_RESULT 8'h10
`define CA_EN 7
`define CA_START 6
`define CA_ATE 5
`define CA_DONE 4
`define CB_HSM 7
`define CB_SRC 0

// ****************************************************************
// Reset values, encodings and timing counts.
// ****************************************************************
`define SEL_RESET 8'h00
`define REF_EXT 2'h0
`define REF_SUPPLY 2'h1
`define REF_INT 2'h3
`define TEMP_CHANNEL 6'h3F
`define FULL_SCALE 10'h3FF
`define CONV_CYCLES 5'd13
`define FIRST_CYCLES 5'd25
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/adc_sel_pkg.sv
package adc_sel_pkg;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_CONV} seq_mode_t;

  typedef struct packed {
    seq_mode_t mode;
    logic [4:0] cnt;
    logic first;
    logic done;
  } seq_state_t;

  typedef struct packed {
    logic [6:0] cnt;
  } presc_state_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic aw_got;
    logic [7:0] wdata;
    logic wlane;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [7:0] sel_tmp;
    logic [7:0] sel_app;
    logic ts_en;
    logic en;
    logic ate;
    logic [2:0] ps;
    logic done_flag;
    logic hsm;
    logic src;
    logic [9:0] result;
    logic start_req;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
  } regs_state_t;

endpackage

// File: rtl/conv_if.sv
`timescale 1ns/1ps

interface conv_if;
  logic en;
  logic [2:0] ps;
  logic presc_clr;
  logic tick;
  logic start_req;
  logic trig_req;
  logic freerun;
  logic lock;
  logic busy;
  logic done;

  modport ctl (
    output en, ps, start_req, trig_req, freerun,
    input tick, lock, busy, done
  );
  modport seq (
    input en, tick, start_req, trig_req, freerun,
    output lock, busy, done, presc_clr
  );
  modport presc (
    input en, ps, presc_clr,
    output tick
  );
endinterface

// File: rtl/presc_div.sv
`timescale 1ns/1ps
`include "adc_sel_params.svh"

module presc_div (
  conv_if.presc cv,
  input wire logic clk_sys,
  input wire logic nrst
);

  adc_sel_pkg::presc_state_t st_r;
  adc_sel_pkg::presc_state_t st_nxt;

  function automatic logic [6:0] div_mask(input logic [2:0] ps);
    logic [7:0] m;
    m = (8'h01 << ps) - 8'h01;
    div_mask = (ps == 3'h0) ? 7'h01 : m[6:0];
  endfunction

  // Converter clock enable; held cleared while the converter is off.
  assign cv.tick = cv.en && (st_r.cnt == div_mask(cv.ps));

  always_comb begin
    st_nxt = st_r;
    if (!cv.en || cv.presc_clr) begin
      st_nxt.cnt = 7'h00;
    end else if (cv.tick) begin
      st_nxt.cnt = 7'h00;
    end else begin
      st_nxt.cnt = st_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: rtl/conv_seq.sv
`timescale 1ns/1ps
`include "adc_sel_params.svh"

module conv_seq (
  conv_if.seq cv,
  input wire logic clk_sys,
  input wire logic nrst
);

  adc_sel_pkg::seq_state_t st_r;
  adc_sel_pkg::seq_state_t st_nxt;
  logic [4:0] len;
  logic last;

  assign len = st_r.first ? `FIRST_CYCLES : `CONV_CYCLES;
  assign last = (st_r.mode == adc_sel_pkg::SEQ_CONV)
    && (st_r.cnt == len - 5'd1);
  assign cv.busy = (st_r.mode != adc_sel_pkg::SEQ_IDLE);
  assign cv.lock = cv.busy && !last;
  assign cv.done = st_r.done;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    cv.presc_clr = 1'b0;
    if (!cv.en) begin
      st_nxt.mode = adc_sel_pkg::SEQ_IDLE;
      st_nxt.cnt = 5'd0;
      st_nxt.first = 1'b1;
    end else begin
      unique case (st_r.mode)
        adc_sel_pkg::SEQ_IDLE: begin
          if (cv.trig_req) begin
            st_nxt.mode = adc_sel_pkg::SEQ_ARMED;
            cv.presc_clr = 1'b1;
          end else if (cv.start_req) begin
            st_nxt.mode = adc_sel_pkg::SEQ_ARMED;
          end
        end
        adc_sel_pkg::SEQ_ARMED: begin
          if (cv.tick) begin
            st_nxt.mode = adc_sel_pkg::SEQ_CONV;
            st_nxt.cnt = 5'd0;
          end
        end
        adc_sel_pkg::SEQ_CONV: begin
          if (cv.tick && last) begin
            st_nxt.done = 1'b1;
            st_nxt.first = 1'b0;
            st_nxt.cnt = 5'd0;
            if (cv.freerun) begin
              st_nxt.mode = adc_sel_pkg::SEQ_CONV;
            end else begin
              st_nxt.mode = adc_sel_pkg::SEQ_IDLE;
            end
          end else if (cv.tick) begin
            st_nxt.cnt = st_r.cnt + 5'd1;
          end
        end
        default: begin
          st_nxt.mode = adc_sel_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{mode: adc_sel_pkg::SEQ_IDLE, cnt: 5'd0,
                first: 1'b1, done: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  lock_on_start_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!cv.busy && cv.en && (cv.start_req || cv.trig_req)) |=> cv.lock)
    else $error("lock not raised at conversion start");

  done_after_last_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (cv.en && last && cv.tick) |-> !cv.lock ##1 cv.done)
    else $error("last cycle not unlocked before done");

endmodule

// File: rtl/adc_sel_latch.sv
`timescale 1ns/1ps
`include "adc_sel_params.svh"

// How it works
// - Software selection held in free temporary register.
// - Applied selection follows temporary while idle.
// - Conversion start freezes the applied selection.
// - Lock reopens in final converter clock cycle.
// - Start on next converter tick; software waits.
// - Auto-trigger selection changes only in safe windows.
// - Free running: running conversion keeps old selection.
// - Reference field picks supply, internal or external.
// - Input above reference gives full scale code.
// - Sensor selected enables temperature sensor driver.
// - Start bit begins conversion, reads busy, self-clears.
// - Trigger edge clears prescaler and starts conversion.
// - Normal conversion lasts thirteen converter clocks.

module adc_sel_latch (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic trig_in,
  input wire logic [9:0] sample_code,
  input wire logic above_ref,
  output logic [5:0] channel_select_field,
  output logic [1:0] reference_select_field,
  output logic ref_supply_en,
  output logic ref_internal_en,
  output logic temp_sensor_en,
  output logic conv_busy,
  output logic conv_done
);

  // ****************************************************************
  // State and submodules.
  // ****************************************************************
  adc_sel_pkg::regs_state_t st_r;
  adc_sel_pkg::regs_state_t st_nxt;
  logic trig_edge;

  conv_if cv ();

  presc_div u_presc (
    .cv(cv.presc),
    .clk_sys(clk_sys),
    .nrst(nrst)
  );

  conv_seq u_seq (
    .cv(cv.seq),
    .clk_sys(clk_sys),
    .nrst(nrst)
  );

  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a == `OFF_SEL_TEMP) || (a == `OFF_CTRL_A)
      || (a == `OFF_CTRL_B) || (a == `OFF_SEL_APPLIED)
      || (a == `OFF_RESULT);
  endfunction

  // ****************************************************************
  // Bus handshakes and block outputs.
  // ****************************************************************
  assign awready = !st_r.aw_got && !st_r.bvalid;
  assign wready = !st_r.w_got && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = {16'h0000, st_r.rdata};
  assign rresp = st_r.rresp;

  assign channel_select_field = st_r.sel_app[5:0];
  assign reference_select_field = st_r.sel_app[7:6];
  assign ref_supply_en = (st_r.sel_app[7:6] == `REF_SUPPLY);
  assign ref_internal_en = (st_r.sel_app[7:6] == `REF_INT);
  assign temp_sensor_en = st_r.ts_en;
  assign conv_busy = cv.busy;
  assign conv_done = st_r.done_flag;

  assign trig_edge = st_r.trig_s2 && !st_r.trig_s3;

  assign cv.en = st_r.en;
  assign cv.ps = st_r.ps;
  assign cv.start_req = st_r.start_req;
  assign cv.freerun = st_r.ate && st_r.src;
  assign cv.trig_req = st_r.ate && st_r.en && !st_r.src
    && trig_edge && !cv.busy;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.start_req = 1'b0;
    st_nxt.trig_s1 = trig_in;
    st_nxt.trig_s2 = st_r.trig_s1;
    st_nxt.trig_s3 = st_r.trig_s2;

    if (awvalid && awready) begin
      st_nxt.awaddr = awaddr;
      st_nxt.aw_got = 1'b1;
    end
    if (wvalid && wready) begin
      st_nxt.wdata = wdata[7:0];
      st_nxt.wlane = wstrb[0];
      st_nxt.w_got = 1'b1;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = map_ok(st_r.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (st_r.wlane) begin
        if (st_r.awaddr == `OFF_SEL_TEMP) begin
          st_nxt.sel_tmp = st_r.wdata;
        end
        if (st_r.awaddr == `OFF_CTRL_A) begin
          st_nxt.en = st_r.wdata[`CA_EN];
          st_nxt.ate = st_r.wdata[`CA_ATE];
          st_nxt.ps = st_r.wdata[2:0];
          if (st_r.wdata[`CA_START] && st_r.wdata[`CA_EN]
              && !cv.busy) begin
            st_nxt.start_req = 1'b1;
          end
          if (st_r.wdata[`CA_DONE]) begin
            st_nxt.done_flag = 1'b0;
          end
        end
        if (st_r.awaddr == `OFF_CTRL_B) begin
          st_nxt.hsm = st_r.wdata[`CB_HSM];
          st_nxt.src = st_r.wdata[`CB_SRC];
        end
      end
    end

    // A completion in the clearing cycle still sets the flag.
    if (cv.done) begin
      st_nxt.done_flag = 1'b1;
      if (above_ref) begin
        st_nxt.result = `FULL_SCALE;
      end else begin
        st_nxt.result = sample_code;
      end
    end

    if (!cv.lock) begin
      st_nxt.sel_app = st_r.sel_tmp;
    end
    st_nxt.ts_en = (st_nxt.sel_app[5:0] == `TEMP_CHANNEL);

    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = map_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (araddr)
        `OFF_SEL_TEMP: begin
          st_nxt.rdata = {8'h00, st_r.sel_tmp};
        end
        `OFF_CTRL_A: begin
          st_nxt.rdata = {8'h00, st_r.en, cv.busy, st_r.ate,
                          st_r.done_flag, 1'b0, st_r.ps};
        end
        `OFF_CTRL_B: begin
          st_nxt.rdata = {8'h00, st_r.hsm, 6'h00, st_r.src};
        end
        `OFF_SEL_APPLIED: begin
          st_nxt.rdata = {6'h00, st_r.ts_en, cv.lock, st_r.sel_app};
        end
        `OFF_RESULT: begin
          st_nxt.rdata = {6'h00, st_r.result};
        end
        default: begin
          st_nxt.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.sel_tmp <= `SEL_RESET;
      st_r.sel_app <= `SEL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  applied_tracks_a: assert property (
    !cv.lock |=> (st_r.sel_app == $past(st_r.sel_tmp)))
    else $error("applied selection did not follow temporary");

  applied_frozen_a: assert property (
    (cv.lock && $past(cv.lock)) |-> $stable(st_r.sel_app))
    else $error("applied selection changed while locked");

  temp_sensor_a: assert property (
    temp_sensor_en == (channel_select_field == `TEMP_CHANNEL))
    else $error("sensor enable disagrees with channel");

  ref_decode_a: assert property (
    ref_internal_en == (reference_select_field == `REF_INT)
    && !(ref_internal_en && ref_supply_en))
    else $error("reference decode wrong");

  full_scale_a: assert property (
    (cv.done && above_ref) |=> (st_r.result == `FULL_SCALE))
    else $error("over-reference input not full scale");

  done_flag_a: assert property (
    cv.done |=> st_r.done_flag)
    else $error("completion did not set flag");

  start_busy_a: assert property (
    (st_r.start_req && st_r.en) |=> cv.busy [*2])
    else $error("start bit not reading busy");

  trig_idle_a: assert property (
    cv.trig_req |-> (!cv.busy && st_r.ate) ##1 cv.lock)
    else $error("trigger accepted during conversion");

  freerun_lock_a: assert property (
    (cv.done && cv.freerun && st_r.en) |-> cv.lock)
    else $error("free running restart not locked");

endmodule

// File: testbench/test_adc_input_select_latch.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end

// ****************************************************************
// Bench for the input selection latch.
// ****************************************************************
module test_adc_input_select_latch;
  logic clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic trig_in, above_ref, awready, wready, bvalid, arready, rvalid;
  logic ref_supply_en, ref_internal_en, temp_sensor_en;
  logic conv_busy, conv_done;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rng;
  logic [9:0] sample_code;
  logic [5:0] channel_select_field;
  logic [1:0] bresp, rresp, reference_select_field;
  int failures, compares, cycles, busy_n;
  typedef struct {string n; logic [31:0] v;} note_t;
  note_t notes[$];

  adc_sel_latch dut (.clk_sys(clk_sys), .nrst(nrst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .trig_in(trig_in), .sample_code(sample_code),
    .above_ref(above_ref), .channel_select_field(channel_select_field),
    .reference_select_field(reference_select_field),
    .ref_supply_en(ref_supply_en), .ref_internal_en(ref_internal_en),
    .temp_sensor_en(temp_sensor_en), .conv_busy(conv_busy),
    .conv_done(conv_done));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [31:0] app(input logic [7:0] s, input logic l);
    return {22'h0, s[5:0] == 6'h3F, l, s};
  endfunction

  task print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  // Takes the oldest note whenever a response is handed over.
  always @(negedge clk_sys) begin : mon
    note_t t;
    if (nrst && (bvalid && bready || rvalid && rready)) begin
      if (notes.size() == 0) begin
        failures++;
        $display("[ERR] notes exp 1 got 0");
      end else begin
        t = notes.pop_front();
        `CHK(t.n, t.v, (bvalid && bready) ? {30'h0, bresp} : rdata)
      end
    end
    if (nrst && rvalid && rready) begin
      `CHK("rresp", 2'h0, rresp)
    end
    if (conv_busy === 1'b1) busy_n++;
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, ga, gw, gb;
    notes.push_back('{"bresp", {30'h0, r}});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ga = 1'b0;
    gw = 1'b0;
    gb = 1'b0;
    while (!(ga && gw)) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      ga |= ta;
      gw |= tw;
    end
    bready <= 1'b1;
    while (!gb) begin
      @(negedge clk_sys);
      gb = bvalid;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic ta, gr;
    notes.push_back('{n, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    gr = 1'b0;
    while (!gr) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      gr = rvalid;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task chk_sel(input logic [7:0] s);
    @(negedge clk_sys);
    `CHK("chan", s[5:0], channel_select_field)
    `CHK("refsel", s[7:6], reference_select_field)
    `CHK("supply", s[7:6] == 2'h1, ref_supply_en)
    `CHK("internal", s[7:6] == 2'h3, ref_internal_en)
    `CHK("sensor", s[5:0] == 6'h3F, temp_sensor_en)
    @(posedge clk_sys);
  endtask

  task wait_done(input logic [5:0] c, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (conv_done !== 1'b1 && n < 400);
    `CHK("chan at done", c, channel_select_field)
    `CHK("span", 1'b1, busy_n >= lo && busy_n <= hi)
    @(posedge clk_sys);
  endtask

  initial begin
    logic [7:0] s, o;
    logic [31:0] w;
    rng = 32'hA99CC14F;
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {trig_in, above_ref, awaddr, araddr, wdata} = 50'h0;
    sample_code = 10'h000;
    {failures, compares, cycles, busy_n} = 128'h0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk_sel(8'h00);
    rd(8'h0C, app(8'h00, 1'b0), "applied");
    for (int i = 0; i < 8; i++) begin
      w = xs();
      s = w[7:0];
      s[7:6] = i[1:0];
      if (i == 0) s[5:0] = 6'h3F;
      wr(8'h00, {24'h0, s}, 2'h0);
      rd(8'h00, {24'h0, s}, "temp");
      rd(8'h0C, app(s, 1'b0), "applied");
      chk_sel(s);
    end
    wr(8'h20, 32'hFF, 2'h2);
    wr(8'h0C, 32'h55, 2'h0);
    rd(8'h0C, app(s, 1'b0), "ro");
    $display("test track finished");
    o = s;
    s = 8'hC5;
    w = xs();
    sample_code <= w[9:0];
    busy_n = 0;
    wr(8'h04, 32'hC0, 2'h0);
    wr(8'h00, {24'h0, s}, 2'h0);
    rd(8'h0C, app(o, 1'b1), "locked");
    rd(8'h04, 32'hC0, "start");
    chk_sel(o);
    wait_done(s[5:0], 49, 55);
    rd(8'h10, {22'h0, w[9:0]}, "result");
    rd(8'h04, 32'h90, "done");
    wr(8'h04, 32'h90, 2'h0);
    rd(8'h04, 32'h80, "clear");
    chk_sel(s);
    $display("test single finished");
    above_ref <= 1'b1;
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h04, 32'hB0, 2'h0);
    o = s;
    s = 8'h42;
    busy_n = 0;
    trig_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    trig_in <= 1'b0;
    wr(8'h00, {24'h0, s}, 2'h0);
    trig_in <= 1'b1;
    chk_sel(o);
    trig_in <= 1'b0;
    wait_done(s[5:0], 25, 31);
    rd(8'h10, 32'h3FF, "result");
    busy_n = 0;
    repeat (40) @(posedge clk_sys);
    `CHK("retrigger", 0, busy_n)
    $display("test trigger finished");
    wr(8'h08, 32'h1, 2'h0);
    busy_n = 0;
    wr(8'h04, 32'hF0, 2'h0);
    wait_done(s[5:0], 25, 31);
    o = s;
    s = 8'h8A;
    wr(8'h04, 32'hB0, 2'h0);
    wr(8'h00, {24'h0, s}, 2'h0);
    chk_sel(o);
    wait_done(s[5:0], 0, 999);
    wr(8'h04, 32'h00, 2'h0);
    s = 8'h17;
    wr(8'h00, {24'h0, s}, 2'h0);
    chk_sel(s);
    busy_n = 0;
    repeat (10) @(posedge clk_sys);
    `CHK("stopped", 0, busy_n)
    $display("test freerun finished");
    s = 8'hFF;
    above_ref <= 1'b0;
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h00, {24'h0, s}, 2'h0);
    chk_sel(s);
    repeat (16) @(posedge clk_sys);
    busy_n = 0;
    wr(8'h04, 32'hD0, 2'h0);
    wait_done(s[5:0], 49, 55);
    w = xs();
    sample_code <= w[9:0];
    busy_n = 0;
    wr(8'h04, 32'hD0, 2'h0);
    wait_done(s[5:0], 25, 31);
    rd(8'h10, {22'h0, w[9:0]}, "sensor");
    $display("test sensor finished");
    print_verdict();
  end
endmodule
